// file: wdt_defs.svh
/*
 * Register offsets, field positions, reset values and codes of the watchdog.
 * Assumes inclusion by bare name from the watchdog package and modules.
 */
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_ADDR_W          12
`define WDT_ADDR_CTRL       12'hfd4
`define WDT_ADDR_CODE       12'hfd8
`define WDT_ADDR_COUNT      12'hfdc
`define WDT_ADDR_STATUS     12'hfe0
`define WDT_ADDR_MASK       12'hfe4

`define WDT_CTRL_RESET      8'ha6
`define WDT_CTRL_RO_MASK    8'hc0
`define WDT_CTRL_RO_VALUE   8'h80
`define WDT_BIT_RUN         5
`define WDT_BIT_OUTSEL      0
`define WDT_TAP_LSB         1
`define WDT_TAP_MSB         2

`define WDT_CLEAR_CODE      8'h4e
`define WDT_COUNT_TOP       8'hff
`define WDT_COUNT_ZERO      8'h00

`define WDT_STAT_IRQ        0
`define WDT_STAT_RST        1
`define WDT_STAT_ZERO       2'h0
`define WDT_MASK_RESET      2'h0

`define WDT_TAP0            5'h04
`define WDT_TAP1            5'h06
`define WDT_TAP2            5'h08
`define WDT_TAP3            5'h0a

`endif

// file: wdt_pkg.sv
/*
 * Types shared by the watchdog modules.
 * Assumes wdt_defs.svh is on the include path.
 */
`default_nettype none
`include "wdt_defs.svh"

package wdt_pkg;
    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`WDT_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage

`default_nettype wire

// file: wdt_prescaler.sv
/*
 * Warm-up timer and tick divider of the watchdog.
 * Assumes one clock and an asynchronous active high reset.
 */
`default_nettype none
`include "wdt_defs.svh"

module wdt_prescaler #(
    parameter int WARMUP_CYCLES = 64,
    parameter int DIV_W         = 16
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control
    input  wire logic [1:0] tapSel,
    // status
    output logic            warmDone,
    output logic            tick
);
    logic [DIV_W-1:0] div_ff;
    logic [31:0]      warm_ff;
    logic             warmDone_ff;
    logic             tick_ff;
    logic [4:0]       tapBits;

    function automatic logic [4:0] tapOf(input logic [1:0] sel);
        case (sel)
            2'h0:    tapOf = `WDT_TAP0;
            2'h1:    tapOf = `WDT_TAP1;
            2'h2:    tapOf = `WDT_TAP2;
            default: tapOf = `WDT_TAP3;
        endcase
    endfunction

    assign tapBits  = tapOf(tapSel);
    assign warmDone = warmDone_ff;
    assign tick     = tick_ff;

    // warm-up after reset, then done forever
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warm_ff     <= 32'h0;
            warmDone_ff <= 1'b0;
        end else if (!warmDone_ff) begin
            warm_ff <= warm_ff + 32'h1;
            if (warm_ff >= 32'(WARMUP_CYCLES - 1)) begin
                warmDone_ff <= 1'b1;
            end
        end
    end

    // divider tick every 2^tap cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_ff + DIV_W'(1);
            tick_ff <= warmDone_ff &&
                       ((div_ff & DIV_W'((32'h1 << tapBits) - 32'h1))
                        == DIV_W'((32'h1 << tapBits) - 32'h1));
        end
    end
endmodule

`default_nettype wire

// file: watchdog_timer_control.sv
/*
 * Watchdog timer with APB register access, interrupt and reset request.
 * Assumes one 50 MHz clock, asynchronous active high reset, APB master
 * on the same clock.
 */
// The implementer's own choice: the APB interface to the registers.
// Notes on behaviour
// - software selects whether an overflow sets the interrupt status bit or sets the reset status bit and raises a reset request
// - watchdog starts by itself once the warm-up after reset ends
// - control bit 5 runs (1) or stops (0) the watchdog, resets to 1
// - eight-bit up counter, cleared by writing the clear code
// - control, clear-code, count monitor and status registers visible to software
// - control at 0x0fd4, top bits read 1 and 0, reset value 10100110
`default_nettype none
`include "wdt_defs.svh"

module watchdog_timer_control #(
    parameter int WARMUP_CYCLES = 64,
    parameter int DIV_W         = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // apb slave
    input  wire wdt_pkg::apb_req_t apbReq,
    output wdt_pkg::apb_rsp_t     apbRsp,
    // watchdog outputs
    output logic                  wdtIrq,
    output logic                  wdtResetReq
);
    import wdt_pkg::*;

    logic [7:0]  ctrl_ff;
    logic [7:0]  count_ff;
    logic [1:0]  status_ff;
    logic [1:0]  mask_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        irq_ff;
    logic        rstReq_ff;
    logic        warmDone;
    logic        tick;
    logic        running;
    logic        overflow;
    logic        accessDone;
    logic        wrDone;
    logic        rdDone;
    logic        codeWrite;
    logic        statusRead;
    logic [1:0]  nxt_status;
    logic [31:0] readMux;
    logic        mapped;

    function automatic logic isMapped(input logic [`WDT_ADDR_W-1:0] a);
        isMapped = (a == `WDT_ADDR_CTRL) || (a == `WDT_ADDR_CODE) ||
                   (a == `WDT_ADDR_COUNT) || (a == `WDT_ADDR_STATUS) ||
                   (a == `WDT_ADDR_MASK);
    endfunction

    wdt_prescaler #(
        .WARMUP_CYCLES (WARMUP_CYCLES),
        .DIV_W         (DIV_W)
    ) u_prescaler (
        .clk      (clk),
        .reset    (reset),
        .tapSel   (ctrl_ff[`WDT_TAP_MSB:`WDT_TAP_LSB]),
        .warmDone (warmDone),
        .tick     (tick)
    );

    // bus handshake terms
    assign accessDone = apbReq.psel && apbReq.penable && pready_ff;
    assign wrDone     = accessDone && apbReq.pwrite;
    assign rdDone     = accessDone && !apbReq.pwrite;
    assign mapped     = isMapped(apbReq.paddr);
    assign codeWrite  = wrDone && (apbReq.paddr == `WDT_ADDR_CODE) &&
                        (apbReq.pwdata[7:0] == `WDT_CLEAR_CODE);
    assign statusRead = rdDone && (apbReq.paddr == `WDT_ADDR_STATUS);

    assign running  = warmDone && ctrl_ff[`WDT_BIT_RUN];
    assign overflow = running && tick && (count_ff == `WDT_COUNT_TOP);

    // read data selection
    always_comb begin
        readMux = 32'h0;
        case (apbReq.paddr)
            `WDT_ADDR_CTRL:   readMux = {24'h0, (ctrl_ff & ~`WDT_CTRL_RO_MASK)
                                         | `WDT_CTRL_RO_VALUE};
            `WDT_ADDR_COUNT:  readMux = {24'h0, count_ff};
            `WDT_ADDR_STATUS: readMux = {30'h0, status_ff};
            `WDT_ADDR_MASK:   readMux = {30'h0, mask_ff};
            default:          readMux = 32'h0;
        endcase
    end

    // apb response: one wait state, then ready
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= apbReq.psel && apbReq.penable && !pready_ff;
            pslverr_ff <= apbReq.psel && apbReq.penable && !pready_ff && !mapped;
            if (apbReq.psel && apbReq.penable && !pready_ff && !apbReq.pwrite) begin
                prdata_ff <= readMux;
            end
        end
    end

    // control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= `WDT_CTRL_RESET;
        end else if (wrDone && (apbReq.paddr == `WDT_ADDR_CTRL)) begin
            ctrl_ff <= (apbReq.pwdata[7:0] & ~`WDT_CTRL_RO_MASK)
                       | `WDT_CTRL_RO_VALUE;
        end
    end

    // mask register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_ff <= `WDT_MASK_RESET;
        end else if (wrDone && (apbReq.paddr == `WDT_ADDR_MASK)) begin
            mask_ff <= apbReq.pwdata[1:0];
        end
    end

    // eight-bit up counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_ff <= `WDT_COUNT_ZERO;
        end else if (codeWrite) begin
            count_ff <= `WDT_COUNT_ZERO;
        end else if (running && tick) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // sticky status, read clears, new event wins
    always_comb begin
        nxt_status = statusRead ? `WDT_STAT_ZERO : status_ff;
        if (overflow && !ctrl_ff[`WDT_BIT_OUTSEL]) begin
            nxt_status[`WDT_STAT_IRQ] = 1'b1;
        end
        if (overflow && ctrl_ff[`WDT_BIT_OUTSEL]) begin
            nxt_status[`WDT_STAT_RST] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff <= `WDT_STAT_ZERO;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_ff    <= 1'b0;
            rstReq_ff <= 1'b0;
        end else begin
            irq_ff    <= |(nxt_status & mask_ff);
            rstReq_ff <= overflow && ctrl_ff[`WDT_BIT_OUTSEL];
        end
    end

    // one driver for the whole response struct
    assign apbRsp         = '{prdata: prdata_ff, pready: pready_ff, pslverr: pslverr_ff};
    assign wdtIrq         = irq_ff;
    assign wdtResetReq    = rstReq_ff;
endmodule

`default_nettype wire

// file: watchdog_timer_control_sva.sv
/* checker: apb and watchdog output timing at the top ports.
   assumes the bind below and the shared defines header. */
`default_nettype none
`include "wdt_defs.svh"
module watchdog_timer_control_chk #(
    parameter int WARMUP_CYCLES = 64,
    parameter int DIV_W         = 16
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // apb and outputs
    input wire wdt_pkg::apb_req_t apbReq,
    input wire wdt_pkg::apb_rsp_t apbRsp,
    input wire logic              wdtIrq,
    input wire logic              wdtResetReq
);
    import wdt_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ready_wait_a: assert property (apbReq.psel && !apbReq.penable |=>
        !apbRsp.pready ##1 apbRsp.pready) else $error("pready not in second access cycle");
    ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready longer than one cycle");
    slverr_map_a: assert property (apbRsp.pslverr |-> apbRsp.pready &&
        !(apbReq.paddr inside {`WDT_ADDR_CTRL, `WDT_ADDR_CODE, `WDT_ADDR_COUNT,
        `WDT_ADDR_STATUS, `WDT_ADDR_MASK})) else $error("pslverr on mapped address");
    ctrl_fixed_a: assert property (apbRsp.pready && !apbReq.pwrite &&
        apbReq.paddr == `WDT_ADDR_CTRL |-> apbRsp.prdata[31:6] == 26'h2)
        else $error("control top bits wrong");
    status_width_a: assert property (apbRsp.pready && !apbReq.pwrite &&
        apbReq.paddr == `WDT_ADDR_STATUS |-> apbRsp.prdata[31:2] == 30'h0)
        else $error("status upper bits set");
    resetreq_pulse_a: assert property (wdtResetReq |=> !wdtResetReq)
        else $error("reset request longer than one cycle");
    output_select_a: assert property (wdtResetReq |-> !$rose(wdtIrq))
        else $error("both outputs raised together");
    warmup_quiet_a: assert property ($fell(reset) |-> (!wdtIrq && !wdtResetReq)[*8])
        else $error("output right after reset");
    cover property ($rose(wdtIrq));
    cover property (wdtResetReq);
    cover property (apbRsp.pslverr);
endmodule
bind watchdog_timer_control watchdog_timer_control_chk #(.WARMUP_CYCLES(WARMUP_CYCLES),
    .DIV_W(DIV_W)) chk_inst (.clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
    .wdtIrq(wdtIrq), .wdtResetReq(wdtResetReq));
`default_nettype wire

// file: watchdog_timer_control_tb_top.sv
/* testbench: register access, overflow in both modes, stop and clear.
   assumes the design, package and defines header are compiled first. */
`default_nettype none
`include "wdt_defs.svh"
module watchdog_timer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    apb_req_t    apbReq = '0;
    apb_rsp_t    apbRsp;
    logic        wdtIrq;
    logic        wdtResetReq;
    logic [31:0] rdat;
    logic [31:0] cnt;
    logic        err;
    int          numErrors = 0;
    int          checks = 0;
    int          cycles = 0;
    always #10 clk = ~clk;
    watchdog_timer_control #(.WARMUP_CYCLES(4), .DIV_W(16)) watchdog_timer_control_inst (
        .clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
        .wdtIrq(wdtIrq), .wdtResetReq(wdtResetReq));
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", numErrors, checks);
        if (numErrors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (apbRsp.pready !== 1'b1) @(posedge clk);
        rdat = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string name, input logic [11:0] adr, input logic [31:0] exp);
        apb(1'b0, adr, 32'h0);
        chk(name, exp, rdat);
    endtask
    task automatic waitOut(input logic sel);
        int n;
        n = 0;
        while ((sel ? wdtResetReq : wdtIrq) !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        chk(sel ? "reset_req" : "irq", 32'h1, {31'h0, sel ? wdtResetReq : wdtIrq});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rdchk("ctrl_reset", `WDT_ADDR_CTRL, 32'ha6);
        rdchk("count_reset", `WDT_ADDR_COUNT, 32'h0);
        apb(1'b1, `WDT_ADDR_CTRL, 32'hff);
        rdchk("ctrl_fixed", `WDT_ADDR_CTRL, 32'hbf);
        rdchk("unmapped", 12'hff0, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b1, `WDT_ADDR_MASK, 32'h1);
        rdchk("mask", `WDT_ADDR_MASK, 32'h1);
        apb(1'b1, `WDT_ADDR_CTRL, 32'ha0);
        repeat (100) @(posedge clk);
        apb(1'b1, `WDT_ADDR_CODE, 32'h12);
        apb(1'b0, `WDT_ADDR_COUNT, 32'h0);
        chk("count_runs", 32'h1, {31'h0, rdat > 32'h4});
        apb(1'b1, `WDT_ADDR_CODE, 32'h4e);
        apb(1'b0, `WDT_ADDR_COUNT, 32'h0);
        chk("count_clear", 32'h1, {31'h0, rdat < 32'h2});
        waitOut(1'b0);
        rdchk("status_irq", `WDT_ADDR_STATUS, 32'h1);
        rdchk("status_clr", `WDT_ADDR_STATUS, 32'h0);
        @(posedge clk);
        chk("irq_low", 32'h0, {31'h0, wdtIrq});
        apb(1'b1, `WDT_ADDR_CTRL, 32'ha1);
        apb(1'b1, `WDT_ADDR_CODE, 32'h4e);
        waitOut(1'b1);
        chk("irq_off", 32'h0, {31'h0, wdtIrq});
        rdchk("status_rst", `WDT_ADDR_STATUS, 32'h2);
        apb(1'b1, `WDT_ADDR_CTRL, 32'h0);
        rdchk("ctrl_stop", `WDT_ADDR_CTRL, 32'h80);
        apb(1'b0, `WDT_ADDR_COUNT, 32'h0);
        cnt = rdat;
        repeat (64) @(posedge clk);
        rdchk("count_held", `WDT_ADDR_COUNT, cnt);
        final_report();
    end
endmodule
`default_nettype wire
